// *** rtl/rmcg_fault_chk.sv ***
`timescale 1ns/100ps
module rmcg_fault_chk (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, high
  rmcg_unit_if.watch u // Unit access and gate view
);
  import rmcg_pkg::*;

  typedef struct packed {
    rmcg_units_t fault;
  } rmcg_chk_state_t;

  rmcg_chk_state_t s;
  rmcg_chk_state_t next_s;

  always_comb
  begin
    next_s = s;
    for (int k = 0; k < NUM_UNITS; k++)
    begin
      next_s.fault[k] = u.req[k] && !u.gate[k];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign u.fault = s.fault;

endmodule : rmcg_fault_chk

// *** rtl/rmcg_top.sv ***
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
module rmcg_top (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [31:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic sleep_i, // System in sleep
  input wire logic deep_sleep_i, // System in deep sleep
  input wire rmcg_pkg::rmcg_units_t unit_req_i, // Per-unit bus access pulse
  output rmcg_pkg::rmcg_units_t unit_clk_en_o, // Per-unit clock enable
  output rmcg_pkg::rmcg_units_t unit_fault_o, // Per-unit bus fault pulse
  output logic irq_o // Fault interrupt, level
);
  import rmcg_pkg::*;

  typedef struct packed {
    rmcg_units_t run;
    rmcg_units_t sleep;
    rmcg_units_t deep;
    logic auto_clock_gating_bit;
    rmcg_units_t status;
    rmcg_units_t mask;
    logic ack;
    logic [31:0] rdata;
    rmcg_units_t gate;
  } rmcg_state_t;

  rmcg_state_t s;
  rmcg_state_t next_s;
  rmcg_reg_t reg_sel;
  rmcg_mode_t mode;
  logic bus_req;
  logic bus_write;
  logic [31:0] wr_word;
  rmcg_units_t status_clr;

  rmcg_unit_if u ();

  assign u.req = unit_req_i;
  assign u.gate = s.gate;

  rmcg_fault_chk chk (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .u (u.watch)
  );

  // A request is answered one edge later; the write lands on the ack edge
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_write = bus_req && wb_we_i && s.ack;

  always_comb
  begin
    reg_sel = RMCG_REG_NONE;
    if (wb_adr_i[31:12] != SYSCTL_BASE[31:12])
    begin
      reg_sel = RMCG_REG_NONE;
    end
    else if (wb_adr_i[11:0] == RUN_GATE_OFF)
    begin
      reg_sel = RMCG_REG_RUN;
    end
    else if (wb_adr_i[11:0] == SLEEP_GATE_OFF)
    begin
      reg_sel = RMCG_REG_SLEEP;
    end
    else if (wb_adr_i[11:0] == DEEP_GATE_OFF)
    begin
      reg_sel = RMCG_REG_DEEP;
    end
    else if (wb_adr_i[11:0] == CLK_CFG_OFF)
    begin
      reg_sel = RMCG_REG_CFG;
    end
    else if (wb_adr_i[11:0] == IRQ_STATUS_OFF)
    begin
      reg_sel = RMCG_REG_STATUS;
    end
    else if (wb_adr_i[11:0] == IRQ_MASK_OFF)
    begin
      reg_sel = RMCG_REG_MASK;
    end
  end

  always_comb
  begin
    mode = RMCG_MODE_RUN;
    if (s.auto_clock_gating_bit && deep_sleep_i)
    begin
      mode = RMCG_MODE_DEEP;
    end
    else if (s.auto_clock_gating_bit && sleep_i)
    begin
      mode = RMCG_MODE_SLEEP;
    end
  end

  always_comb
  begin
    next_s = s;
    wr_word = rmcg_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    status_clr = '0;
    next_s.ack = bus_req && !s.ack;

    if (bus_req && !s.ack)
    begin
      next_s.rdata = 32'h0000_0000;
      case (reg_sel)
        RMCG_REG_RUN: next_s.rdata = rmcg_units_to_reg(s.run);
        RMCG_REG_SLEEP: next_s.rdata = rmcg_units_to_reg(s.sleep);
        RMCG_REG_DEEP: next_s.rdata = rmcg_units_to_reg(s.deep);
        RMCG_REG_CFG: next_s.rdata[ACG_BIT] = s.auto_clock_gating_bit;
        RMCG_REG_STATUS: next_s.rdata = 32'(s.status);
        RMCG_REG_MASK: next_s.rdata = 32'(s.mask);
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end

    if (bus_write)
    begin
      case (reg_sel)
        RMCG_REG_RUN:
        begin
          next_s.run = rmcg_reg_to_units(rmcg_merge(rmcg_units_to_reg(s.run), wb_dat_i,
                                                    wb_sel_i));
        end
        RMCG_REG_SLEEP:
        begin
          next_s.sleep = rmcg_reg_to_units(rmcg_merge(rmcg_units_to_reg(s.sleep), wb_dat_i,
                                                      wb_sel_i));
        end
        RMCG_REG_DEEP:
        begin
          next_s.deep = rmcg_reg_to_units(rmcg_merge(rmcg_units_to_reg(s.deep), wb_dat_i,
                                                     wb_sel_i));
        end
        RMCG_REG_CFG:
        begin
          if (wb_sel_i[0])
          begin
            next_s.auto_clock_gating_bit = wb_dat_i[ACG_BIT];
          end
        end
        RMCG_REG_STATUS: status_clr = wr_word[NUM_UNITS-1:0];
        RMCG_REG_MASK: next_s.mask = rmcg_units_t'(rmcg_merge(32'(s.mask), wb_dat_i, wb_sel_i));
        default: next_s.run = s.run;
      endcase
    end

    // fault events sticky, set beats clear
    next_s.status = (s.status & ~status_clr) | u.fault;

    case (mode)
      RMCG_MODE_RUN: next_s.gate = s.run;
      RMCG_MODE_SLEEP: next_s.gate = s.sleep;
      RMCG_MODE_DEEP: next_s.gate = s.deep;
      default: next_s.gate = s.run;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign unit_clk_en_o = s.gate;
  assign unit_fault_o = u.fault;
  assign irq_o = |(s.status & s.mask);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence run_write_s;
    wb_cyc_i && wb_stb_i && wb_we_i && s.ack && (reg_sel == RMCG_REG_RUN);
  endsequence

  sequence run_read_s;
    wb_cyc_i && wb_stb_i && !wb_we_i && !s.ack && (reg_sel == RMCG_REG_RUN);
  endsequence

  sequence gated_access_s;
    (unit_req_i & ~unit_clk_en_o) != '0;
  endsequence

  sequence status_write_s;
    wb_cyc_i && wb_stb_i && wb_we_i && s.ack && (reg_sel == RMCG_REG_STATUS);
  endsequence

  sequence unmapped_read_s;
    wb_cyc_i && wb_stb_i && !wb_we_i && !s.ack && (reg_sel == RMCG_REG_NONE);
  endsequence

  run_gate_follow_a: assert property (
    !s.auto_clock_gating_bit |=> unit_clk_en_o == $past(s.run))
    else $error("clock enables do not follow run gating");

  run_mode_only_a: assert property (
    (!sleep_i && !deep_sleep_i) |=> unit_clk_en_o == $past(s.run))
    else $error("run gating not in force while running");

  gated_fault_a: assert property (
    gated_access_s |=> (unit_fault_o == $past(unit_req_i & ~unit_clk_en_o)))
    else $error("access to unclocked unit gave wrong fault");

  fault_only_gated_a: assert property (
    ((unit_req_i & unit_clk_en_o) != '0)
      |=> (unit_fault_o & $past(unit_req_i & unit_clk_en_o)) == '0)
    else $error("access to clocked unit gave a fault");

  fault_sticky_a: assert property (
    (unit_fault_o != '0) |=> ((s.status & $past(unit_fault_o)) == $past(unit_fault_o)))
    else $error("fault event not caught in status");

  status_hold_a: assert property (
    ((s.status != '0) && !(wb_cyc_i && wb_stb_i && wb_we_i && s.ack))
      |=> (s.status & $past(s.status)) == $past(s.status))
    else $error("fault status lost without a clear");

  status_clear_a: assert property (
    (status_write_s and (unit_fault_o == '0))
      |=> (s.status & $past(wr_word[NUM_UNITS-1:0])) == '0)
    else $error("fault status not cleared by writing one");

  reset_clear_a: assert property (
    disable iff (1'b0) rst_i |=> (s.run == '0) && (unit_clk_en_o == '0))
    else $error("reset left a unit clocked");

  reset_idle_a: assert property (
    disable iff (1'b0) rst_i |=> !wb_ack_o && (unit_fault_o == '0) && !irq_o)
    else $error("reset left an output active");

  phy_mac_bits_a: assert property (
    (run_write_s and (wb_sel_i[3] == 1'b1)) |=> s.run[UNIT_PHY] == $past(wb_dat_i[PHY_BIT])
      && s.run[UNIT_MAC] == $past(wb_dat_i[MAC_BIT]))
    else $error("phy or mac gate bit mismatch");

  mac_bit_a: assert property (
    (run_write_s and (wb_sel_i[3] == 1'b1))
      |=> s.run[UNIT_MAC] == $past(wb_dat_i[MAC_BIT]))
    else $error("mac gate bit mismatch");

  port_bits_a: assert property (
    (run_write_s and (wb_sel_i[0] == 1'b1))
      |=> s.run[NUM_PORTS-1:0] == $past(wb_dat_i[NUM_PORTS-1:0]))
    else $error("port gate bits mismatch");

  sleep_select_a: assert property (
    (s.auto_clock_gating_bit && sleep_i && !deep_sleep_i) |=> unit_clk_en_o == $past(s.sleep))
    else $error("sleep gating not applied with automatic gating");

  deep_select_a: assert property (
    (s.auto_clock_gating_bit && deep_sleep_i) |=> unit_clk_en_o == $past(s.deep))
    else $error("deep sleep gating not applied with automatic gating");

  no_auto_run_a: assert property (
    (!s.auto_clock_gating_bit && (sleep_i || deep_sleep_i)) |=> unit_clk_en_o == $past(s.run))
    else $error("run gating not kept in sleep without automatic gating");

  run_read_back_a: assert property (
    run_read_s |=> wb_ack_o && (wb_dat_o == rmcg_units_to_reg($past(s.run))) ##1 !wb_ack_o)
    else $error("run gating read back wrong");

  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  unmapped_zero_a: assert property (
    unmapped_read_s |=> wb_ack_o && (wb_dat_o == 32'h0000_0000))
    else $error("unmapped read not answered with zero");

  reserved_zero_a: assert property (
    run_read_s |=> (wb_dat_o & ~GATE_IMPL_MASK) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

endmodule : rmcg_top

// *** shared/rmcg_pkg.sv ***
package rmcg_pkg;

  // System-control block placement
  localparam logic [31:0] SYSCTL_BASE = 32'h400f_e000;
  localparam logic [11:0] RUN_GATE_OFF = 12'h108;
  localparam logic [11:0] SLEEP_GATE_OFF = 12'h118;
  localparam logic [11:0] DEEP_GATE_OFF = 12'h128;
  localparam logic [11:0] CLK_CFG_OFF = 12'h300;
  localparam logic [11:0] IRQ_STATUS_OFF = 12'h304;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h308;

  // Gate register layout
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;
  localparam logic [31:0] GATE_IMPL_MASK = 32'h5000_007f;
  localparam int PHY_BIT = 30;
  localparam int MAC_BIT = 28;
  localparam int PORT_A_BIT = 0;
  localparam int NUM_PORTS = 7;
  localparam int NUM_UNITS = 9;
  localparam int UNIT_PHY = 8;
  localparam int UNIT_MAC = 7;
  localparam int ACG_BIT = 0;

  typedef logic [NUM_UNITS-1:0] rmcg_units_t;

  typedef enum {
    RMCG_REG_NONE,
    RMCG_REG_RUN,
    RMCG_REG_SLEEP,
    RMCG_REG_DEEP,
    RMCG_REG_CFG,
    RMCG_REG_STATUS,
    RMCG_REG_MASK
  } rmcg_reg_t;

  typedef enum {
    RMCG_MODE_RUN,
    RMCG_MODE_SLEEP,
    RMCG_MODE_DEEP
  } rmcg_mode_t;

  function automatic rmcg_units_t rmcg_reg_to_units(input logic [31:0] r);
    rmcg_units_t u;
    u = '0;
    u[UNIT_PHY] = r[PHY_BIT];
    u[UNIT_MAC] = r[MAC_BIT];
    u[NUM_PORTS-1:0] = r[PORT_A_BIT +: NUM_PORTS];
    return u;
  endfunction : rmcg_reg_to_units

  // Reserved positions always come back as zero
  function automatic logic [31:0] rmcg_units_to_reg(input rmcg_units_t u);
    logic [31:0] r;
    r = GATE_RESET;
    r[PHY_BIT] = u[UNIT_PHY];
    r[MAC_BIT] = u[UNIT_MAC];
    r[PORT_A_BIT +: NUM_PORTS] = u[NUM_PORTS-1:0];
    return r;
  endfunction : rmcg_units_to_reg

  // Byte-lane merge of a Wishbone write into an old word
  function automatic logic [31:0] rmcg_merge(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return r;
  endfunction : rmcg_merge

endpackage : rmcg_pkg

// *** shared/rmcg_unit_if.sv ***
`timescale 1ns/100ps
interface rmcg_unit_if;
  import rmcg_pkg::*;
  rmcg_units_t req;
  rmcg_units_t gate;
  rmcg_units_t fault;
  modport owner (output req, output gate, input fault);
  modport watch (input req, input gate, output fault);
endinterface : rmcg_unit_if

// *** testbench/tb_rmcg_top.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_rmcg_top;
  import rmcg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic sleep_i = 1'b0;
  logic deep_sleep_i = 1'b0;
  rmcg_units_t unit_req_i = '0;
  rmcg_units_t unit_clk_en_o;
  rmcg_units_t unit_fault_o;
  logic irq_o;
  int mismatches = 0;
  int tests_run = 0;
  logic [31:0] rd;

  always #5 clk_i = ~clk_i;

  rmcg_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_i(sleep_i), .deep_sleep_i(deep_sleep_i),
    .unit_req_i(unit_req_i), .unit_clk_en_o(unit_clk_en_o), .unit_fault_o(unit_fault_o),
    .irq_o(irq_o));

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // Called just after a rising edge; waits for ack under a bound
  task automatic wb(input logic we, input logic [11:0] off, input logic [31:0] d,
                    input logic [3:0] sel, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= SYSCTL_BASE + {20'h0, off};
    wb_dat_i <= d;
    wb_sel_i <= sel;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      report_and_stop();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // Enables trail the register by a cycle
  task automatic settle();
    repeat (2) @(posedge clk_i);
  endtask : settle

  task automatic t_reset();
    wb(1'b0, RUN_GATE_OFF, 32'h0, 4'hf, rd);
    `CHK(rd, 32'h0000_0000)
    `CHK(unit_clk_en_o, 9'h000)
    `CHK(irq_o, 1'b0)
    $display("test reset done");
  endtask : t_reset

  task automatic t_gates();
    int b;
    for (int k = 0; k < 9; k++)
    begin
      b = (k < 7) ? k : ((k == 7) ? 28 : 30);
      wb(1'b1, RUN_GATE_OFF, 32'h1 << b, 4'hf, rd);
      settle();
      `CHK(unit_clk_en_o, rmcg_units_t'(1) << k)
      wb(1'b0, RUN_GATE_OFF, 32'h0, 4'hf, rd);
      `CHK(rd, 32'h1 << b)
    end
    wb(1'b1, RUN_GATE_OFF, 32'hffff_ffff, 4'hf, rd);
    wb(1'b0, RUN_GATE_OFF, 32'h0, 4'hf, rd);
    `CHK(rd, 32'h5000_007f)
    settle();
    `CHK(unit_clk_en_o, 9'h1ff)
    // Only the low lane written: ports cleared, Ethernet gates kept
    wb(1'b1, RUN_GATE_OFF, 32'h0, 4'h1, rd);
    wb(1'b0, RUN_GATE_OFF, 32'h0, 4'hf, rd);
    `CHK(rd, 32'h5000_0000)
    // read-modify-write passes reserved bits back as read
    wb(1'b0, RUN_GATE_OFF, 32'h0, 4'hf, rd);
    wb(1'b1, RUN_GATE_OFF, rd | 32'h0000_0004, 4'hf, rd);
    wb(1'b0, RUN_GATE_OFF, 32'h0, 4'hf, rd);
    `CHK(rd, 32'h5000_0004)
    $display("test gates done");
  endtask : t_gates

  task automatic t_unmapped();
    wb(1'b1, 12'h10c, 32'hffff_ffff, 4'hf, rd);
    wb(1'b0, 12'h10c, 32'h0, 4'hf, rd);
    `CHK(rd, 32'h0)
    wb(1'b1, RUN_GATE_OFF, 32'h0, 4'hf, rd);
    wb(1'b1, 12'h100, 32'hffff_ffff, 4'hf, rd);
    wb(1'b0, RUN_GATE_OFF, 32'h0, 4'hf, rd);
    `CHK(rd, 32'h0)
    $display("test unmapped done");
  endtask : t_unmapped

  task automatic t_faults();
    wb(1'b1, RUN_GATE_OFF, 32'h4, 4'hf, rd);
    wb(1'b1, IRQ_MASK_OFF, 32'h1, 4'hf, rd);
    settle();
    unit_req_i <= 9'h187;
    @(posedge clk_i);
    unit_req_i <= '0;
    @(posedge clk_i);
    `CHK(unit_fault_o, 9'h183)
    @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    wb(1'b0, IRQ_STATUS_OFF, 32'h0, 4'hf, rd);
    `CHK(rd, 32'h0000_0183)
    wb(1'b1, IRQ_STATUS_OFF, 32'h1, 4'hf, rd);
    @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    wb(1'b1, IRQ_STATUS_OFF, 32'h182, 4'hf, rd);
    wb(1'b0, IRQ_STATUS_OFF, 32'h0, 4'hf, rd);
    `CHK(rd, 32'h0)
    $display("test faults done");
  endtask : t_faults

  task automatic t_sleep();
    wb(1'b1, RUN_GATE_OFF, 32'h0000_0001, 4'hf, rd);
    wb(1'b1, SLEEP_GATE_OFF, 32'h4000_0000, 4'hf, rd);
    wb(1'b1, DEEP_GATE_OFF, 32'h1000_0000, 4'hf, rd);
    sleep_i <= 1'b1;
    settle();
    `CHK(unit_clk_en_o, 9'h001)
    wb(1'b1, CLK_CFG_OFF, 32'h1, 4'hf, rd);
    settle();
    `CHK(unit_clk_en_o, 9'h100)
    deep_sleep_i <= 1'b1;
    settle();
    `CHK(unit_clk_en_o, 9'h080)
    sleep_i <= 1'b0;
    deep_sleep_i <= 1'b0;
    settle();
    `CHK(unit_clk_en_o, 9'h001)
    $display("test sleep done");
  endtask : t_sleep

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_gates();
    t_unmapped();
    t_faults();
    t_sleep();
    report_and_stop();
  end
endmodule : tb_rmcg_top
